// ===== rtl/hpc_pkg.sv
// Constants for the hub port command executor
// Assumes a 100 MHz hub clock
package hpc_pkg;
	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned RESET_MS       = 15;
	localparam int unsigned RESUME_MS      = 20;
	localparam int unsigned RESET_CYCLES   = RESET_MS * 1000 * CLK_MHZ;
	localparam int unsigned RESUME_CYCLES  = RESUME_MS * 1000 * CLK_MHZ;
	localparam int unsigned LS_EOP_CYCLES  = 2 * 667;
	localparam int unsigned CNT_W          = 22;
	localparam int unsigned NPORT          = 4;
	localparam int unsigned INT_PORT       = 3;
	localparam logic [2:0]  CMD_DISABLE    = 3'h0;
	localparam logic [2:0]  CMD_ENABLE     = 3'h1;
	localparam logic [2:0]  CMD_RESET      = 3'h2;
	localparam logic [2:0]  CMD_SUSPEND    = 3'h3;
	localparam logic [2:0]  CMD_RESUME     = 3'h4;
	localparam logic [1:0]  LINE_IDLE      = 2'h0;
	localparam logic [1:0]  LINE_SE0       = 2'h1;
	localparam logic [1:0]  LINE_K         = 2'h2;
	localparam logic [1:0]  LINE_J         = 2'h3;
	typedef enum logic [2:0] {
		HPC_IDLE    = 3'b000,
		HPC_WAITBUS = 3'b001,
		HPC_TIMED   = 3'b011,
		HPC_EOP     = 3'b010,
		HPC_EOF     = 3'b110
	} hpc_state_t;
endpackage

// ===== rtl/hpc_executor.sv
// Hub port command executor: one command at a time, four ports
// Assumes firmware strobe, bus idle and frame end are synchronous to sys_clk
// Summary of operation
// - Codes 000/001 disable/enable selected port at next bus idle.
// - Code 010 external: drive SE0 at once 15 ms, then enable.
// - Code 010 internal: reset function interface unit and FIFO logic.
// - Code 010 internal: reset defined function registers to defaults.
// - Internal reset: enable port automatically after 15 ms.
// - Code 011 external: idle J from next bus idle, block traffic.
// - Code 011 internal: suspend function port at next bus idle.
// - Code 100 external: K for 20 ms, low-speed EOP, then enable.
// - Code 100 internal: enable after 20 ms.
// - Internal port always reported connected.
// - Undefined command codes are ignored.
// - Port index selects the port a command acts on.
// - Port state change shows in status only at next end of frame.
`timescale 1ns/1ps
module hpc_executor (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        cmd_wr,
	input  wire logic [2:0]  port_command_register,
	input  wire logic [1:0]  port_select_index,
	input  wire logic        bus_idle,
	input  wire logic        frame_end,
	input  wire logic [2:0]  port_connect_in,
	output logic      [7:0]  port_line_state,
	output logic      [3:0]  port_enabled,
	output logic      [3:0]  port_suspended,
	output logic      [3:0]  port_connected,
	output logic      [3:0]  port_traffic_ok,
	output logic             fiu_fifo_reset,
	output logic             func_reg_reset,
	output logic             busy
);
	// ============================================================
	// State
	typedef struct packed {
		hpc_pkg::hpc_state_t    st;
		logic [2:0]             cmd;
		logic [1:0]             port;
		logic [hpc_pkg::CNT_W-1:0] cnt;
		logic [3:0]             en;
		logic [3:0]             sus;
		logic [3:0]             en_stat;
		logic [3:0]             sus_stat;
		logic [3:0]             conn;
		// Connect pins pass two flops; only the second is read by logic
		logic [2:0]             conn_s1;
		logic [2:0]             conn_s2;
		logic [7:0]             line;
		logic                   frst;
		logic                   rrst;
		logic                   bsy;
		logic [3:0]             tok;
	} hpc_regs_t;

	hpc_regs_t s_reg;
	hpc_regs_t s_next;

	function automatic logic valid_cmd(input logic [2:0] c);
		return c <= hpc_pkg::CMD_RESUME;
	endfunction

	function automatic logic [7:0] set_line(input logic [7:0] l, input logic [1:0] p,
		input logic [1:0] v);
		logic [7:0] r;
		r = l;
		r[2*p +: 2] = v;
		return r;
	endfunction

	// ============================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.conn_s1 = port_connect_in;
		s_next.conn_s2 = s_reg.conn_s1;
		s_next.frst = 1'b0;
		s_next.rrst = 1'b0;
		unique case (s_reg.st)
			hpc_pkg::HPC_IDLE: begin
				if (cmd_wr && valid_cmd(port_command_register)) begin
					s_next.cmd  = port_command_register;
					s_next.port = port_select_index;
					s_next.cnt  = '0;
					if (port_command_register == hpc_pkg::CMD_RESET ||
					    port_command_register == hpc_pkg::CMD_RESUME) begin
						s_next.st = hpc_pkg::HPC_TIMED;
						if (port_select_index != 2'(hpc_pkg::INT_PORT)) begin
							s_next.line = set_line(s_reg.line, port_select_index,
								port_command_register == hpc_pkg::CMD_RESET ?
								hpc_pkg::LINE_SE0 : hpc_pkg::LINE_K);
						end
						s_next.en[port_select_index] = 1'b0;
					end else begin
						s_next.st = hpc_pkg::HPC_WAITBUS;
					end
				end
			end
			hpc_pkg::HPC_WAITBUS: begin
				if (bus_idle) begin
					s_next.st = hpc_pkg::HPC_EOF;
					unique case (s_reg.cmd)
						hpc_pkg::CMD_DISABLE: begin
							s_next.en[s_reg.port]  = 1'b0;
							s_next.sus[s_reg.port] = 1'b0;
						end
						hpc_pkg::CMD_ENABLE: begin
							s_next.en[s_reg.port]  = 1'b1;
							s_next.sus[s_reg.port] = 1'b0;
						end
						default: begin
							s_next.sus[s_reg.port] = 1'b1;
							if (s_reg.port != 2'(hpc_pkg::INT_PORT))
								s_next.line = set_line(s_reg.line, s_reg.port,
									hpc_pkg::LINE_J);
						end
					endcase
				end
			end
			hpc_pkg::HPC_TIMED: begin
				s_next.cnt = s_reg.cnt + 1'b1;
				if (s_reg.cmd == hpc_pkg::CMD_RESET && s_reg.port == 2'(hpc_pkg::INT_PORT)) begin
					s_next.frst = 1'b1;
					s_next.rrst = 1'b1;
				end
				if ((s_reg.cmd == hpc_pkg::CMD_RESET &&
				     s_reg.cnt == hpc_pkg::CNT_W'(hpc_pkg::RESET_CYCLES - 1)) ||
				    (s_reg.cmd == hpc_pkg::CMD_RESUME &&
				     s_reg.cnt == hpc_pkg::CNT_W'(hpc_pkg::RESUME_CYCLES - 1))) begin
					s_next.cnt = '0;
					if (s_reg.cmd == hpc_pkg::CMD_RESUME &&
					    s_reg.port != 2'(hpc_pkg::INT_PORT)) begin
						s_next.st = hpc_pkg::HPC_EOP;
						s_next.line = set_line(s_reg.line, s_reg.port, hpc_pkg::LINE_SE0);
					end else begin
						s_next.st = hpc_pkg::HPC_EOF;
						s_next.en[s_reg.port]  = 1'b1;
						s_next.sus[s_reg.port] = 1'b0;
						s_next.line = set_line(s_reg.line, s_reg.port, hpc_pkg::LINE_IDLE);
					end
				end
			end
			hpc_pkg::HPC_EOP: begin
				s_next.cnt = s_reg.cnt + 1'b1;
				if (s_reg.cnt == hpc_pkg::CNT_W'(hpc_pkg::LS_EOP_CYCLES - 1)) begin
					s_next.st = hpc_pkg::HPC_EOF;
					s_next.en[s_reg.port]  = 1'b1;
					s_next.sus[s_reg.port] = 1'b0;
					s_next.line = set_line(s_reg.line, s_reg.port, hpc_pkg::LINE_IDLE);
				end
			end
			hpc_pkg::HPC_EOF: begin
				if (frame_end)
					s_next.st = hpc_pkg::HPC_IDLE;
			end
			default: s_next.st = hpc_pkg::HPC_IDLE;
		endcase
		if (frame_end) begin
			s_next.en_stat  = s_reg.en;
			s_next.sus_stat = s_reg.sus;
			// suspended or disabled ports pass nothing
			s_next.tok      = s_reg.en & ~s_reg.sus;
			s_next.conn = {1'b1, s_reg.conn_s2};
		end
		// Busy from a flop, so firmware never sees a decode glitch
		s_next.bsy = (s_next.st != hpc_pkg::HPC_IDLE);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '{st: hpc_pkg::HPC_IDLE, cmd: 3'h0, port: 2'h0, cnt: '0,
				en: 4'h0, sus: 4'h0, en_stat: 4'h0, sus_stat: 4'h0, conn: 4'h8,
				conn_s1: 3'h0, conn_s2: 3'h0, line: 8'h00, frst: 1'b0, rrst: 1'b0,
				bsy: 1'b0, tok: 4'h0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ============================================================
	// Outputs, all from flops
	assign port_line_state = s_reg.line;
	assign port_enabled    = s_reg.en_stat;
	assign port_suspended  = s_reg.sus_stat;
	assign port_connected  = s_reg.conn;
	assign port_traffic_ok = s_reg.tok;
	assign fiu_fifo_reset  = s_reg.frst;
	assign func_reg_reset  = s_reg.rrst;
	assign busy            = s_reg.bsy;

	// ============================================================
	// Checks
	internal_connected_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		port_connected[3]) else $error("internal port not connected");
	bad_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register > 3'h4) |=> !busy)
		else $error("undefined code started a command");
	no_restart_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(busy && cmd_wr) |=> $stable(s_reg.port) && $stable(s_reg.cmd))
		else $error("command restarted while busy");
	se0_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register == 3'h2 && port_select_index != 2'h3)
		|=> port_line_state[2*s_reg.port +: 2] == 2'h1) else $error("SE0 not driven at once");
	k_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register == 3'h4 && port_select_index == 2'h1)
		|=> port_line_state[3:2] == 2'h2) else $error("K not driven at once");
	int_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register == 3'h2 && port_select_index == 2'h3)
		|=> ##1 fiu_fifo_reset && func_reg_reset) else $error("internal reset missing");
	wait_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_WAITBUS && !bus_idle) |=> s_reg.en == $past(s_reg.en))
		else $error("enable changed before bus idle");
	status_eof_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!frame_end |=> $stable(port_enabled)) else $error("status moved off frame end");
	suspend_j_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_WAITBUS && bus_idle && s_reg.cmd == 3'h3 &&
		 s_reg.port != 2'h3) |=> port_line_state[2*s_reg.port +: 2] == 2'h3)
		else $error("no J on suspend");

	// ============================================================
	// Checks: command intake
	// Writes while busy are dropped with no flag; firmware must watch busy
	busy_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register <= hpc_pkg::CMD_RESUME) |=> busy)
		else $error("defined code did not start a command");

	cmd_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register <= hpc_pkg::CMD_RESUME)
		|=> s_reg.cmd == $past(port_command_register))
		else $error("command code not latched at write");

	port_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!busy && cmd_wr && port_command_register <= hpc_pkg::CMD_RESUME)
		|=> s_reg.port == $past(port_select_index))
		else $error("port index not latched at write");

	enable_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_WAITBUS && bus_idle && s_reg.cmd == hpc_pkg::CMD_ENABLE)
		|=> s_reg.en[s_reg.port]) else $error("port not enabled at bus idle");

	disable_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_WAITBUS && bus_idle && s_reg.cmd == hpc_pkg::CMD_DISABLE)
		|=> !s_reg.en[s_reg.port]) else $error("port not disabled at bus idle");

	int_suspend_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_WAITBUS && bus_idle && s_reg.cmd == hpc_pkg::CMD_SUSPEND &&
		 s_reg.port == 2'(hpc_pkg::INT_PORT)) |=> s_reg.sus[3])
		else $error("internal port not suspended at bus idle");

	// ============================================================
	// Checks: timed commands
	// Full lengths are too long to run, so holds and starts are guarded
	reset_se0_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_TIMED && s_reg.cmd == hpc_pkg::CMD_RESET &&
		 s_reg.port != 2'(hpc_pkg::INT_PORT))
		|-> port_line_state[2*s_reg.port +: 2] == hpc_pkg::LINE_SE0)
		else $error("SE0 not held during port reset");

	resume_k_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_TIMED && s_reg.cmd == hpc_pkg::CMD_RESUME &&
		 s_reg.port != 2'(hpc_pkg::INT_PORT))
		|-> port_line_state[2*s_reg.port +: 2] == hpc_pkg::LINE_K)
		else $error("K not held during port resume");

	reset_no_enable_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_TIMED && s_reg.cmd == hpc_pkg::CMD_RESET)
		|-> !s_reg.en[s_reg.port]) else $error("port enabled before reset ended");

	resume_sus_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_TIMED && s_reg.cmd == hpc_pkg::CMD_RESUME &&
		 s_reg.cnt != hpc_pkg::CNT_W'(hpc_pkg::RESUME_CYCLES - 1))
		|=> $stable(s_reg.sus)) else $error("resume ended early");

	fifo_reset_src_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		fiu_fifo_reset |-> $past(s_reg.st) == hpc_pkg::HPC_TIMED &&
		$past(s_reg.cmd) == hpc_pkg::CMD_RESET && $past(s_reg.port) == 2'(hpc_pkg::INT_PORT))
		else $error("function reset outside an internal port reset");

	reg_reset_pair_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		func_reg_reset == fiu_fifo_reset) else $error("register reset apart from unit reset");

	// ============================================================
	// Checks: ports and status
	status_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!frame_end |=> $stable(port_suspended) && $stable(port_connected) &&
		$stable(port_traffic_ok)) else $error("suspend or connect status moved off frame end");

	eof_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_reg.st == hpc_pkg::HPC_EOF && !frame_end) |=> busy)
		else $error("command ended before frame end");

	traffic_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(port_traffic_ok & port_suspended) == 4'h0) else $error("suspended port passes traffic");

	int_line_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		port_line_state[7:6] == 2'h0) else $error("internal port drives a line state");
endmodule

// ===== dv/hpc_bus_model.sv
// Downstream bus timing model: bus idle and end of frame
// Assumes busy marks a command in progress on the executor
`timescale 1ns/1ps
module hpc_bus_model (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       busy,
	input  wire logic [7:0] idle_delay,
	output logic            bus_idle,
	output logic            frame_end,
	output logic      [2:0] port_connect_in
);
	// ==========================================
	// Traffic then idle, frame end six cycles on
	logic [8:0] cnt_reg;
	// Two devices attached, middle port empty
	assign port_connect_in = 3'h5;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg   <= 9'h000;
			bus_idle  <= 1'b0;
			frame_end <= 1'b0;
		end else if (busy) begin
			cnt_reg   <= cnt_reg + 9'h001;
			bus_idle  <= (cnt_reg >= {1'b0, idle_delay});
			frame_end <= (cnt_reg == {1'b0, idle_delay} + 9'h006);
		end else begin
			// Bus busy with traffic between commands
			cnt_reg   <= 9'h000;
			bus_idle  <= 1'b0;
			frame_end <= 1'b0;
		end
	end
endmodule

// ===== dv/hpc_executor_tb.sv
// Self-checking bench for the hub port command executor
// Assumes the bus model answers every command; timed ends are too long to await
`timescale 1ns/1ps
module hpc_executor_tb;
	logic       sys_clk;
	logic       nrst;
	logic       cmd_wr;
	logic [2:0] code;
	logic [1:0] idx;
	logic [7:0] idle_delay;
	logic       bus_idle;
	logic       frame_end;
	logic [2:0] conn;
	logic [7:0] line;
	logic [3:0] en;
	logic [3:0] susp;
	logic [3:0] con;
	logic [3:0] tok;
	logic       fiu_rst;
	logic       freg_rst;
	logic       busy;
	int         fails;
	int         cmp_count;
	int         cycles;
	hpc_executor hpc_executor_i (.sys_clk(sys_clk), .nrst(nrst), .cmd_wr(cmd_wr),
		.port_command_register(code), .port_select_index(idx), .bus_idle(bus_idle),
		.frame_end(frame_end), .port_connect_in(conn), .port_line_state(line),
		.port_enabled(en), .port_suspended(susp), .port_connected(con),
		.port_traffic_ok(tok), .fiu_fifo_reset(fiu_rst), .func_reg_reset(freg_rst),
		.busy(busy));
	hpc_bus_model hpc_bus_model_i (.sys_clk(sys_clk), .nrst(nrst), .busy(busy),
		.idle_delay(idle_delay), .bus_idle(bus_idle), .frame_end(frame_end),
		.port_connect_in(conn));
	// ==========================================
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		nrst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 nrst = 1'b1;
	endtask
	task automatic issue(input logic [2:0] c, input logic [1:0] p);
		@(posedge sys_clk);
		#1 cmd_wr = 1'b1;
		code = c;
		idx = p;
		@(posedge sys_clk);
		#1 cmd_wr = 1'b0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (bus_idle !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk({7'h00, bus_idle}, 8'h01);
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk({7'h00, busy}, 8'h00);
	endtask
	task automatic conclude();
		$display("compares=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_enable();
		idle_delay = 8'h20;
		// firmware sets index with the write
		issue(hpc_pkg::CMD_ENABLE, 2'h0);
		issue(hpc_pkg::CMD_SUSPEND, 2'h1);
		wait_idle();
		chk({4'h0, en}, 8'h00);
		wait_done();
		chk({en, tok}, 8'h11);
		chk({4'h0, susp}, 8'h00);
		chk({4'h0, con}, 8'h0d);
		for (int c = 5; c < 8; c++) begin
			issue(c[2:0], 2'h0);
			chk({7'h00, busy}, 8'h00);
		end
		$display("test enable done");
	endtask
	task automatic t_suspend();
		idle_delay = 8'h00;
		issue(hpc_pkg::CMD_ENABLE, 2'h3);
		wait_done();
		issue(hpc_pkg::CMD_DISABLE, 2'h3);
		wait_done();
		chk({4'h0, en}, 8'h01);
		issue(hpc_pkg::CMD_SUSPEND, 2'h0);
		wait_idle();
		@(posedge sys_clk);
		#1 chk({6'h00, line[1:0]}, {6'h00, hpc_pkg::LINE_J});
		wait_done();
		chk({susp, tok}, 8'h10);
		// firmware suspends internal port after low power entry
		issue(hpc_pkg::CMD_SUSPEND, 2'h3);
		wait_done();
		chk({4'h0, susp}, 8'h09);
		$display("test suspend done");
	endtask
	task automatic t_timed();
		do_reset();
		issue(hpc_pkg::CMD_RESET, 2'h2);
		@(posedge sys_clk);
		#1 chk({6'h00, line[5:4]}, {6'h00, hpc_pkg::LINE_SE0});
		do_reset();
		issue(hpc_pkg::CMD_RESUME, 2'h1);
		@(posedge sys_clk);
		#1 chk({6'h00, line[3:2]}, {6'h00, hpc_pkg::LINE_K});
		do_reset();
		// executor resets the function unit and its registers meanwhile
		issue(hpc_pkg::CMD_RESET, 2'h3);
		@(posedge sys_clk);
		#1 chk({6'h00, fiu_rst, freg_rst}, 8'h03);
		chk({con, 4'h0}, 8'h80);
		do_reset();
		// firmware wakes the function before resuming its port
		issue(hpc_pkg::CMD_RESUME, 2'h3);
		@(posedge sys_clk);
		#1 chk(line, 8'h00);
		chk({6'h00, fiu_rst, freg_rst}, 8'h00);
		chk({7'h00, busy}, 8'h01);
		$display("test timed starts done");
	endtask
	// ==========================================
	// Clock, timeout and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		{cmd_wr, code, idx, idle_delay} = '0;
		{fails, cmp_count} = '0;
		do_reset();
		chk({con, tok}, 8'h80);
		chk(line, 8'h00);
		t_enable();
		t_suspend();
		t_timed();
		conclude();
	end
endmodule
